// File: arc_far_model.sv
// Protection stage and breaker side model issuing breaker requests
`timescale 1ns/1ps
module arc_far_model (
  input  wire logic       clk_i,        // Clock
  output logic            close_req_o,  // Close request pulse
  output logic            open_req_o,   // Open request pulse
  output logic [2:0]      open_cause_o  // Opening cause
);
  initial begin
    close_req_o = 1'b0;
    open_req_o = 1'b0;
    open_cause_o = 3'h0;
  end
  // One-cycle pulses; cause held afterwards so it never floats
  task automatic do_open(input logic [2:0] c);
    @(posedge clk_i);
    open_req_o <= 1'b1;
    open_cause_o <= c;
    @(posedge clk_i);
    open_req_o <= 1'b0;
  endtask
  task automatic do_close();
    @(posedge clk_i);
    close_req_o <= 1'b1;
    @(posedge clk_i);
    close_req_o <= 1'b0;
  endtask
endmodule

// File: arc_pkg.sv
// Package with constants and types for the auto-reclose settings block
package arc_pkg;
  localparam int unsigned CLK_HZ       = 200_000_000;
  localparam int unsigned SET_TICK_MS  = 10;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * SET_TICK_MS;
  localparam int unsigned N_SHOT       = 5;
  localparam int unsigned N_LINE       = 4;
  localparam logic [15:0] DEAD_RST     = 16'h01F4;
  localparam logic [15:0] PULSE_RST    = 16'h0014;
  localparam logic [15:0] ZERO_RST     = 16'h0000;
  localparam logic [9:0]  MAINT_RST    = 10'h3E7;
  localparam logic [1:0]  MODE_NONE    = 2'h0;
  localparam logic [1:0]  MODE_START   = 2'h1;
  localparam logic [1:0]  MODE_BLOCK   = 2'h2;
  localparam logic [7:0]  FAULT_LEAD   = 8'h01;
  localparam logic [9:0]  A_MODE       = 10'h000;
  localparam logic [9:0]  A_DEAD       = 10'h020;
  localparam logic [9:0]  A_SDLY       = 10'h040;
  localparam logic [9:0]  A_DISC       = 10'h080;
  localparam logic [9:0]  A_FTEN       = 10'h0A0;
  localparam logic [9:0]  A_FTDLY      = 10'h0A4;
  localparam logic [9:0]  A_CLOSE      = 10'h0C0;
  localparam logic [9:0]  A_OPEN       = 10'h0C4;
  localparam logic [9:0]  A_STRESS     = 10'h0E0;
  localparam logic [9:0]  A_MAINT      = 10'h100;
  localparam logic [9:0]  A_PRELVL     = 10'h104;
  localparam logic [9:0]  A_STAT       = 10'h108;
  localparam logic [9:0]  A_IRQ_ST     = 10'h10C;
  localparam logic [9:0]  A_IRQ_MSK    = 10'h110;
  localparam logic [9:0]  A_FAULT      = 10'h114;
  localparam logic [9:0]  A_CMD        = 10'h118;
  localparam int unsigned IRQ_W        = 4;
  typedef enum logic [2:0] {
    PS_IDLE = 3'b001,
    PS_RUN  = 3'b010,
    PS_WAIT = 3'b100
  } arc_pulse_e;
endpackage

// File: arc_pulse.sv
// Breaker command pulse of a programmable length in 10 ms ticks
`timescale 1ns/1ps
module arc_pulse (
  input  wire logic        clk_i,  // System clock
  input  wire logic        rst_i,  // Synchronous reset
  input  wire logic        ce_i,   // Clock enable
  input  wire logic        tick_i, // 10 ms tick
  arc_pulse_if.gen         pif     // Request and state
);
  import arc_pkg::*;
  arc_pulse_e  st_q, st_d;
  logic [15:0] cnt_q, cnt_d;

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      PS_IDLE: begin
        if (pif.fire) begin
          st_d  = PS_RUN;
          cnt_d = pif.len;
        end
      end
      PS_RUN: begin
        if (tick_i) begin
          if (cnt_q <= 16'h0001) st_d = PS_WAIT;
          else cnt_d = cnt_q - 16'h0001;
        end
      end
      PS_WAIT: begin
        // One idle cycle so back-to-back requests give separate pulses
        st_d = PS_IDLE;
      end
      default: st_d = PS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q  <= PS_IDLE;
      cnt_q <= 16'h0000;
    end else if (ce_i) begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  assign pif.active = (st_q == PS_RUN);
endmodule

// File: arc_pulse_if.sv
// Interface carrying one breaker pulse request and its state
`timescale 1ns/1ps
interface arc_pulse_if;
  logic        fire;
  logic [15:0] len;
  logic        active;
  modport ctl (output fire, output len, input active);
  modport gen (input fire, input len, output active);
endinterface

// File: arc_settings.sv
// Auto-reclose settings store, breaker wear monitor and supervision
//   Contract
// - A permanent supervision fault lights the red alarm indicator.
// - The same fault drives the supervision output relay control.
// - The fault code is a leading 1 plus a code number, never cleared.
// - Each shot holds three 2-bit modes for lines one to three, reset 0.
// - Each shot holds a 2-bit mode for line four, reset 0.
// - Each shot holds a dead time, reset 5 s.
// - Each shot holds a start delay per initiation line, reset 0 s.
// - Each line has a final-trip enable, reset 0.
// - Each line has a final-trip delay, reset 0 s.
// - The close command is a pulse of programmable length, 0.2 s reset.
// - The open command is a pulse of programmable length, 0.2 s reset.
// - Each shot holds a discriminating time, reset 0 s.
// - Manual and per-line opening stress factors are held, reset 0.
// - Maintenance counter resets to 999 and pre-alarm level to 0.
// - Pre-alarm and alarm are shown apart, reset auto or by hand.
`timescale 1ns/1ps
module arc_settings (
  input  wire logic        clk_i,        // 200 MHz clock
  input  wire logic        rst_i,        // Synchronous reset
  input  wire logic        ce_i,         // Clock enable
  input  wire logic [31:0] wb_adr_i,     // Wishbone address
  input  wire logic [31:0] wb_dat_i,     // Wishbone write data
  output logic      [31:0] wb_dat_o,     // Wishbone read data
  input  wire logic [3:0]  wb_sel_i,     // Byte selects
  input  wire logic        wb_we_i,      // Write enable
  input  wire logic        wb_cyc_i,     // Cycle
  input  wire logic        wb_stb_i,     // Strobe
  output logic             wb_ack_o,     // Acknowledge
  input  wire logic        pnl_we_i,     // Front panel write strobe
  input  wire logic [9:0]  pnl_adr_i,    // Front panel address
  input  wire logic [15:0] pnl_dat_i,    // Front panel data
  input  wire logic        fault_i,      // Permanent fault detected
  input  wire logic [7:0]  fault_code_i, // Fault code number
  input  wire logic        close_req_i,  // Request breaker close
  input  wire logic        open_req_i,   // Request breaker open
  input  wire logic [2:0]  open_cause_i, // 0 manual, 1..4 line
  output logic             cb_close_o,   // Breaker close command
  output logic             cb_open_o,    // Breaker open command
  output logic             sv_led_o,     // Red supervision indicator
  output logic             sv_relay_o,   // Supervision output relay
  output logic [15:0]      fault_disp_o, // Lead digit and code
  output logic             prealarm_o,   // Maintenance pre-alarm
  output logic             alarm_o,      // Maintenance alarm
  output logic             irq_o         // Interrupt
);
  import arc_pkg::*;

  // Setting storage, one array per table column
  logic [1:0]  mode_q   [N_SHOT][N_LINE];
  logic [15:0] dead_q   [N_SHOT];
  logic [15:0] sdly_q   [N_SHOT][N_LINE];
  logic [15:0] disc_q   [N_SHOT];
  logic [N_LINE-1:0] ften_q;
  logic [15:0] ftdly_q  [N_LINE];
  logic [15:0] close_q, open_q;
  logic [5:0]  stress_q [N_LINE+1];
  logic [9:0]  maint_q, maint_d;
  logic [9:0]  prelvl_q;
  logic        pre_q, pre_d, alm_q, alm_d;
  logic        flt_q, flt_d;
  logic [7:0]  code_q, code_d;
  logic [IRQ_W-1:0] ist_q, ist_d, imsk_q;
  logic        ack_q, ack_d;
  logic [31:0] rd_q, rd_d;
  // One bit more than it looks: 2,000,000 cycles do not fit in 20 bits
  logic [20:0] tick_cnt_q;
  logic        tick;

  // Common write port fed by panel or bus
  logic        w_en;
  logic [9:0]  w_adr;
  logic [15:0] w_dat;
  logic        bus_req, bus_wr;

  assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign bus_wr  = bus_req && wb_we_i && wb_sel_i[0];

  always_comb begin
    // Bus wins a same-cycle collision; the panel may retry next cycle
    if (bus_wr) begin
      w_en  = 1'b1;
      w_adr = wb_adr_i[9:0];
      w_dat = wb_sel_i[1] ? wb_dat_i[15:0] : {8'h00, wb_dat_i[7:0]};
    end else begin
      w_en  = pnl_we_i;
      w_adr = pnl_adr_i;
      w_dat = pnl_dat_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_q <= 21'h000000;
    end else if (ce_i) begin
      if (tick) tick_cnt_q <= 21'h000000;
      else tick_cnt_q <= tick_cnt_q + 21'h000001;
    end
  end
  assign tick = (tick_cnt_q == 21'(TICK_CYCLES - 1));

  // Per-shot settings
  for (genvar s = 0; s < N_SHOT; s++) begin : g_shot
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        dead_q[s] <= DEAD_RST;
        disc_q[s] <= ZERO_RST;
      end else if (ce_i && w_en) begin
        if (w_adr == A_DEAD + 10'(4 * s)) dead_q[s] <= w_dat;
        if (w_adr == A_DISC + 10'(4 * s)) disc_q[s] <= w_dat;
      end
    end
    for (genvar l = 0; l < N_LINE; l++) begin : g_line
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          mode_q[s][l] <= MODE_NONE;
          sdly_q[s][l] <= ZERO_RST;
        end else if (ce_i && w_en) begin
          if (w_adr == A_MODE + 10'(4 * s)) begin
            // Code 3 is not a legal mode and is kept out
            if (w_dat[2*l+:2] != 2'h3) mode_q[s][l] <= w_dat[2*l+:2];
          end
          if (w_adr == A_SDLY + 10'(16 * s + 4 * l))
            sdly_q[s][l] <= w_dat;
        end
      end
    end
  end

  // Per-line final trip settings, manual and per-line stress settings
  for (genvar l = 0; l < N_LINE + 1; l++) begin : g_stress
    always_ff @(posedge clk_i) begin
      if (rst_i) stress_q[l] <= 6'h00;
      else if (ce_i && w_en && w_adr == A_STRESS + 10'(4 * l))
        stress_q[l] <= (w_dat > 16'h0032) ? 6'h32 : w_dat[5:0];
    end
  end
  for (genvar l = 0; l < N_LINE; l++) begin : g_ft
    always_ff @(posedge clk_i) begin
      if (rst_i) ftdly_q[l] <= ZERO_RST;
      else if (ce_i && w_en && w_adr == A_FTDLY + 10'(4 * l))
        ftdly_q[l] <= w_dat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ften_q   <= '0;
      close_q  <= PULSE_RST;
      open_q   <= PULSE_RST;
      prelvl_q <= 10'h000;
      imsk_q   <= '0;
    end else if (ce_i && w_en) begin
      if (w_adr == A_FTEN) ften_q <= w_dat[N_LINE-1:0];
      if (w_adr == A_CLOSE) close_q <= w_dat;
      if (w_adr == A_OPEN) open_q <= w_dat;
      if (w_adr == A_PRELVL) prelvl_q <= w_dat[9:0];
      if (w_adr == A_IRQ_MSK) imsk_q <= w_dat[IRQ_W-1:0];
    end
  end

  // Breaker command pulses
  arc_pulse_if cls_if ();
  arc_pulse_if opn_if ();
  assign cls_if.fire = close_req_i;
  assign cls_if.len  = close_q;
  assign opn_if.fire = open_req_i;
  assign opn_if.len  = open_q;

  arc_pulse u_close (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .tick_i (tick),
    .pif    (cls_if)
  );
  arc_pulse u_open (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .tick_i (tick),
    .pif    (opn_if)
  );
  assign cb_close_o = cls_if.active;
  assign cb_open_o  = opn_if.active;

  // Wear monitor, supervision, interrupts
  logic [5:0] dec;
  logic       open_ev, pre_set, alm_set, ack_pre, ack_alm;
  assign open_ev = open_req_i && !opn_if.active;
  // Causes 5 to 7 do not exist; they wear nothing rather than
  // indexing past the end of the stress table
  always_comb begin
    dec = 6'h00;
    for (int k = 0; k < N_LINE + 1; k++) begin
      if (open_cause_i == 3'(k)) dec = stress_q[k];
    end
  end
  assign ack_pre = w_en && w_adr == A_CMD && w_dat[0];
  assign ack_alm = w_en && w_adr == A_CMD && w_dat[1];

  always_comb begin
    maint_d = maint_q;
    if (w_en && w_adr == A_MAINT) begin
      maint_d = (w_dat > 16'(MAINT_RST)) ? MAINT_RST : w_dat[9:0];
    end else if (open_ev) begin
      maint_d = (maint_q > 10'(dec)) ? maint_q - 10'(dec) : 10'h000;
    end
    pre_set = (maint_d <= prelvl_q) && (maint_q > prelvl_q ||
              (open_ev && maint_d <= prelvl_q));
    alm_set = (maint_d == 10'h000) && open_ev;
    // Auto reset when the counter is refilled above the level; set wins
    pre_d = pre_set || (pre_q && !ack_pre && maint_d <= prelvl_q);
    alm_d = alm_set || (alm_q && !ack_alm && maint_d == 10'h000);
    flt_d  = flt_q || fault_i;
    code_d = (fault_i && !flt_q) ? fault_code_i : code_q;
    ist_d  = ist_q;
    if (w_en && w_adr == A_IRQ_ST) ist_d = ist_q & ~w_dat[IRQ_W-1:0];
    ist_d = ist_d | {fault_i && !flt_q, alm_set, pre_set, open_ev};
    ack_d = bus_req;
    rd_d  = 32'h00000000;
    unique case (wb_adr_i[9:0])
      A_FTEN:    rd_d = {28'h0000000, ften_q};
      A_CLOSE:   rd_d = {16'h0000, close_q};
      A_OPEN:    rd_d = {16'h0000, open_q};
      A_MAINT:   rd_d = {22'h000000, maint_q};
      A_PRELVL:  rd_d = {22'h000000, prelvl_q};
      A_STAT:    rd_d = {26'h0000000, cb_open_o, cb_close_o, flt_q,
                         alm_q, pre_q, tick};
      A_IRQ_ST:  rd_d = {28'h0000000, ist_q};
      A_IRQ_MSK: rd_d = {28'h0000000, imsk_q};
      A_FAULT:   rd_d = {16'h0000, fault_disp_o};
      default: begin
        for (int s = 0; s < N_SHOT; s++) begin
          if (wb_adr_i[9:0] == A_MODE + 10'(4 * s))
            rd_d = {24'h000000, mode_q[s][3], mode_q[s][2],
                    mode_q[s][1], mode_q[s][0]};
          if (wb_adr_i[9:0] == A_DEAD + 10'(4 * s))
            rd_d = {16'h0000, dead_q[s]};
          if (wb_adr_i[9:0] == A_DISC + 10'(4 * s))
            rd_d = {16'h0000, disc_q[s]};
          for (int l = 0; l < N_LINE; l++) begin
            if (wb_adr_i[9:0] == A_SDLY + 10'(16 * s + 4 * l))
              rd_d = {16'h0000, sdly_q[s][l]};
          end
        end
        for (int l = 0; l < N_LINE + 1; l++) begin
          if (wb_adr_i[9:0] == A_STRESS + 10'(4 * l))
            rd_d = {26'h0000000, stress_q[l]};
          if (l < N_LINE && wb_adr_i[9:0] == A_FTDLY + 10'(4 * l))
            rd_d = {16'h0000, ftdly_q[l]};
        end
      end
    endcase
    if (!bus_req || wb_we_i) rd_d = rd_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      maint_q <= MAINT_RST;
      pre_q   <= 1'b0;
      alm_q   <= 1'b0;
      flt_q   <= 1'b0;
      code_q  <= 8'h00;
      ist_q   <= '0;
      ack_q   <= 1'b0;
      rd_q    <= 32'h00000000;
    end else if (ce_i) begin
      maint_q <= maint_d;
      pre_q   <= pre_d;
      alm_q   <= alm_d;
      flt_q   <= flt_d;
      code_q  <= code_d;
      ist_q   <= ist_d;
      ack_q   <= ack_d;
      rd_q    <= rd_d;
    end
  end

  assign sv_led_o     = flt_q;
  assign sv_relay_o   = flt_q;
  // Only power-on reset clears it; no command path reaches code_q
  assign fault_disp_o = flt_q ? {FAULT_LEAD, code_q} : 16'h0000;
  assign prealarm_o   = pre_q;
  assign alarm_o      = alm_q;
  assign irq_o        = |(ist_q & imsk_q);
  assign wb_ack_o     = ack_q;
  assign wb_dat_o     = rd_q;
endmodule

// File: arc_settings_asserts.sv
// Checker of the auto-reclose settings block ports
`timescale 1ns/1ps
module arc_settings_asserts
  import arc_pkg::*;
(
  input wire logic        clk_i,        // Clock
  input wire logic        rst_i,        // Reset
  input wire logic        wb_cyc_i,     // Cycle
  input wire logic        wb_stb_i,     // Strobe
  input wire logic        wb_ack_o,     // Acknowledge
  input wire logic        fault_i,      // Fault
  input wire logic        close_req_i,  // Close request
  input wire logic        open_req_i,   // Open request
  input wire logic        cb_close_o,   // Close command
  input wire logic        cb_open_o,    // Open command
  input wire logic        sv_led_o,     // Indicator
  input wire logic        sv_relay_o,   // Relay control
  input wire logic [15:0] fault_disp_o  // Display
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_idle_close;
    close_req_i && !cb_close_o && !$past(cb_close_o);
  endsequence
  sequence s_idle_open;
    open_req_i && !cb_open_o && !$past(cb_open_o);
  endsequence
  a_bus_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_bus_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_fault_lights_led: assert property (fault_i |=> sv_led_o)
    else $error("fault did not light indicator");
  a_led_relay_tied: assert property (sv_led_o == sv_relay_o)
    else $error("relay differs from indicator");
  a_fault_code_lead: assert property (sv_led_o |-> fault_disp_o[15:8] == FAULT_LEAD)
    else $error("fault code lead digit wrong");
  a_fault_code_held: assert property (sv_led_o && $past(sv_led_o) |-> $stable(fault_disp_o) && sv_led_o)
    else $error("fault code changed");
  a_close_pulse_start: assert property (s_idle_close |=> cb_close_o [*8])
    else $error("close pulse not started or too short");
  a_open_pulse_start: assert property (s_idle_open |=> cb_open_o [*8])
    else $error("open pulse not started or too short");
endmodule
bind arc_settings arc_settings_asserts u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .fault_i(fault_i), .close_req_i(close_req_i),
  .open_req_i(open_req_i), .cb_close_o(cb_close_o), .cb_open_o(cb_open_o),
  .sv_led_o(sv_led_o), .sv_relay_o(sv_relay_o), .fault_disp_o(fault_disp_o));

// File: testbench.sv
// Self-checking bench of the auto-reclose settings block
`timescale 1ns/1ps
module testbench;
  import arc_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [31:0] adr = 32'h0, dat = 32'h0, dat_o;
  logic        pnl_we = 1'b0, fault = 1'b0, ce = 1'b1, close_req, open_req;
  logic [9:0]  pnl_adr = 10'h000;
  logic [15:0] pnl_dat = 16'h0000, disp;
  logic [7:0]  code = 8'h2A;
  logic [2:0]  cause;
  logic        ack, cbc, cbo, led, rly, pre, alm, irq;
  int          n_mismatch = 0, tests_run = 0;
  always #2.5 clk_i = ~clk_i;
  arc_far_model far (.clk_i(clk_i), .close_req_o(close_req),
    .open_req_o(open_req), .open_cause_o(cause));
  arc_settings uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_sel_i(4'hF),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .pnl_we_i(pnl_we), .pnl_adr_i(pnl_adr), .pnl_dat_i(pnl_dat),
    .fault_i(fault), .fault_code_i(code), .close_req_i(close_req),
    .open_req_i(open_req), .open_cause_i(cause), .cb_close_o(cbc),
    .cb_open_o(cbo), .sv_led_o(led), .sv_relay_o(rly), .fault_disp_o(disp),
    .prealarm_o(pre), .alarm_o(alm), .irq_o(irq));
  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Holds the request until ack is sampled, data taken at that edge
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, 22'h0, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 100);
    q = dat_o;
    {cyc, stb, we} <= 3'b000;
    if (n >= 100) begin
      n_mismatch++;
      results();
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic t_defaults();
    for (int s = 0; s < N_SHOT; s++) begin
      rd(A_MODE + 10'(4 * s), 32'h0);
      rd(A_DEAD + 10'(4 * s), {16'h0, DEAD_RST});
      rd(A_DISC + 10'(4 * s), 32'h0);
      for (int l = 0; l < N_LINE; l++)
        rd(A_SDLY + 10'(16 * s + 4 * l), 32'h0);
    end
    rd(A_FTEN, 32'h0);
    for (int l = 0; l < N_LINE; l++) rd(A_FTDLY + 10'(4 * l), 32'h0);
    rd(A_CLOSE, {16'h0, PULSE_RST});
    rd(A_OPEN, {16'h0, PULSE_RST});
    for (int k = 0; k <= N_LINE; k++) rd(A_STRESS + 10'(4 * k), 32'h0);
    rd(A_MAINT, {22'h0, MAINT_RST});
    rd(A_PRELVL, 32'h0);
    rd(10'h3FC, 32'h0);
  endtask
  task automatic t_writes();
    wr(A_MODE + 10'h008, 32'h0000_0066);
    rd(A_MODE + 10'h008, 32'h0000_0066);
    @(posedge clk_i);
    {pnl_we, pnl_adr, pnl_dat} <= {1'b1, A_DEAD + 10'h004, 16'h0123};
    @(posedge clk_i);
    pnl_we <= 1'b0;
    rd(A_DEAD + 10'h004, 32'h0000_0123);
    wr(A_DEAD + 10'h004, 32'h0000_0200);
    rd(A_DEAD + 10'h004, 32'h0000_0200);
    wr(A_STRESS + 10'h004, 32'd60);
    rd(A_STRESS + 10'h004, 32'd50);
    wr(A_STRESS + 10'h008, 32'd100);
    rd(A_STRESS + 10'h008, 32'd50);
  endtask
  // Clock enable low: a panel write must not land
  task automatic t_freeze();
    @(posedge clk_i);
    {ce, pnl_we, pnl_adr, pnl_dat} <= {1'b0, 1'b1, A_DISC, 16'h0077};
    @(posedge clk_i);
    {ce, pnl_we} <= 2'b10;
    rd(A_DISC, 32'h0);
  endtask
  // Counter reaches zero on one opening: alarm and pre-alarm together
  task automatic t_wear();
    wr(A_PRELVL, 32'd10);
    wr(A_MAINT, 32'd5);
    wr(A_STRESS + 10'h004, 32'd5);
    wr(A_IRQ_MSK, 32'h0);
    far.do_open(3'h1);
    rd(A_MAINT, 32'h0);
    chk({30'h0, pre, alm}, 32'h3);
    chk({31'h0, irq}, 32'h0);
    rd(A_IRQ_ST, 32'h7);
    wr(A_IRQ_MSK, 32'hF);
    rd(A_STRESS, 32'h0);
    chk({31'h0, irq}, 32'h1);
    wr(A_IRQ_ST, 32'h7);
    rd(A_IRQ_ST, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(A_CMD, 32'h2);
    chk({30'h0, pre, alm}, 32'h2);
    wr(A_MAINT, 32'd100);
    rd(A_MAINT, 32'd100);
    chk({30'h0, pre, alm}, 32'h0);
    far.do_close();
    rd(A_FAULT, 32'h0);
    chk({30'h0, cbc, cbo}, 32'h3);
  endtask
  task automatic t_fault();
    @(posedge clk_i);
    fault <= 1'b1;
    @(posedge clk_i);
    fault <= 1'b0;
    code <= 8'h55;
    wr(A_CMD, 32'h3);
    rd(A_CMD, 32'h0);
    chk({30'h0, led, rly}, 32'h3);
    chk({16'h0, disp}, {16'h0, FAULT_LEAD, 8'h2A});
    rd(A_FAULT, {16'h0, FAULT_LEAD, 8'h2A});
    rd(A_STAT, 32'h0000_0038);
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_defaults();
    t_writes();
    t_freeze();
    t_wear();
    t_fault();
    results();
  end
endmodule
